// >>> src/cub_pkg.sv
// Shared constants, carriers and state layouts for the channel-status and user-bit buffer.
package cub_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int MCLK_TIMEOUT_NS = 2000;
    // Master clock declared lost after this many cycles without an edge (longest time).
    localparam int MCLK_TIMEOUT_CYC = MCLK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int MON_CNT_W = 8;
    localparam logic [MON_CNT_W-1:0] MCLK_TIMEOUT_LAST = MON_CNT_W'(MCLK_TIMEOUT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer geometry.
    localparam int BUF_BITS = 384;
    localparam int FRAMES = 192;
    localparam int FIX_BITS = 40;
    localparam int POS_W = 9;
    localparam logic [POS_W-1:0] POS_FIRST = 9'h000;
    localparam logic [POS_W-1:0] POS_LAST = 9'h17f;
    localparam logic [POS_W-1:0] POS_CH_B = 9'h0c0;
    localparam int WORD_BITS = 32;
    localparam int WIDX_W = 4;
    // First five bytes of each channel's status block.
    localparam logic [BUF_BITS-1:0] FIX_MASK = {{(FRAMES - FIX_BITS){1'b0}}, {FIX_BITS{1'b1}},
                                                {(FRAMES - FIX_BITS){1'b0}}, {FIX_BITS{1'b1}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses, low twelve bits decoded).
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_IST0 = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_ICLR0 = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_IEN0 = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_IST1 = 12'h014;
    localparam logic [ADDR_W-1:0] ADDR_ICLR1 = 12'h018;
    localparam logic [ADDR_W-1:0] ADDR_IEN1 = 12'h01c;
    localparam logic [ADDR_W-1:0] ADDR_BUF_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] ADDR_BUF_LAST = 12'h12c;
    localparam int STAT_POS_LSB = 8;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Interrupt event bits.
    localparam int EV_W = 2;
    localparam int EV0_CAPTURE = 0;
    localparam int EV0_TXLOAD = 1;
    localparam int EV1_RECOVERED_MASTER_CLOCK_LOST = 0;
    localparam int EV1_OUTPUT_MASTER_CLOCK_LOST = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {IFMT_HIGH, IFMT_LOW, IFMT_PULSE} cub_ifmt_t;
    typedef enum logic {PH_IDLE, PH_ACCESS} cub_phase_t;

    // Control register; run is bit 0.
    typedef struct packed {
        cub_ifmt_t ifmt;
        logic serial_mode;
        logic auto_user;
        logic fixed_cs;
        logic buffer_kind_select;
        logic run;
    } cub_ctrl_t;
    localparam int CTRL_W = $bits(cub_ctrl_t);

    // One subframe of channel-status and user bits on the link.
    typedef struct packed {
        logic blk_start;
        logic sub_b;
        logic user;
        logic cs;
    } cub_link_t;

    // Edge monitor state.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic [MON_CNT_W-1:0] cnt;
        logic alive;
    } cub_mon_t;

endpackage

// >>> src/cub_edge_mon.sv
// Synchroniser, rising-edge finder and activity watchdog for one slow outside clock.
`timescale 1ns/1ns
module cub_edge_mon (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sig_in,
    output logic rise,
    output logic alive
);
    import cub_pkg::*;

    cub_mon_t q;
    cub_mon_t d;

    ////////////////////////////////////////////////////////////////////////////////
    // Two flops synchronise; the third only feeds the rising-edge and activity compares.
    always_comb begin
        d = q;
        d.s1 = sig_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = q.s2 & ~q.s3;
        if (q.s2 != q.s3) begin
            d.cnt = '0;
            d.alive = 1'b1;
        end else if (q.cnt == MCLK_TIMEOUT_LAST) begin
            d.alive = 1'b0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = q.rise;
    assign alive = q.alive;

endmodule // cub_edge_mon

// >>> src/cub_buffer.sv
// Three-stage channel-status and user-bit buffer with an AHB-Lite register slave.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module cub_buffer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rx_link_clk,
    input wire cub_pkg::cub_link_t rx_link,
    input wire logic tx_link_clk,
    output cub_pkg::cub_link_t tx_link,
    input wire logic recovered_master_clock,
    input wire logic output_master_clock,
    output logic serial_mode,
    output logic irq
);
    import cub_pkg::*;

    typedef struct packed {
        cub_phase_t ph;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic hrdy;
        logic resp;
        logic [31:0] rdata;
        cub_ctrl_t ctrl;
        logic [EV_W-1:0] st0;
        logic [EV_W-1:0] en0;
        logic [EV_W-1:0] st1;
        logic [EV_W-1:0] en1;
        logic pend;
        logic irq;
        logic rm_prev;
        logic om_prev;
        cub_link_t rx_s1;
        cub_link_t rx_s2;
        logic [POS_W-1:0] rx_pos;
        logic [BUF_BITS-1:0] cap_cs;
        logic [BUF_BITS-1:0] cap_u;
        logic [BUF_BITS-1:0] acc_cs;
        logic [BUF_BITS-1:0] acc_u;
        logic [BUF_BITS-1:0] tx_cs;
        logic [BUF_BITS-1:0] tx_u;
        logic [POS_W-1:0] tx_pos;
        logic fixed_done;
        cub_link_t txo;
    } cub_state_t;

    cub_state_t q;
    cub_state_t d;
    logic rx_rise;
    logic tx_rise;
    logic rm_alive;
    logic om_alive;
    logic run_ok;
    logic in_buf;
    logic cap_done;
    logic tx_done;
    logic pend_now;
    logic tx_u_bit;
    logic tx_cs_bit;
    logic [POS_W-1:0] rx_eff;
    logic [WIDX_W-1:0] widx;
    logic [EV_W-1:0] ev0;
    logic [EV_W-1:0] ev1;
    logic [EV_W-1:0] clr0;
    logic [EV_W-1:0] clr1;
    logic [BUF_BITS-1:0] fixed_part;

    // Position in a block counts subframes; status bits sit at channel base plus frame.
    function automatic logic [POS_W-1:0] cs_index(input logic [POS_W-1:0] pos);
        cs_index = pos[0] ? POS_CH_B + (pos >> 1) : (pos >> 1);
    endfunction

    // One 32-bit word of a 384-bit buffer.
    function automatic logic [31:0] get_word(input logic [BUF_BITS-1:0] b,
                                             input logic [WIDX_W-1:0] i);
        get_word = b[i * WORD_BITS +: WORD_BITS];
    endfunction

    // Buffer with one 32-bit word replaced.
    function automatic logic [BUF_BITS-1:0] put_word(input logic [BUF_BITS-1:0] b,
                                                     input logic [WIDX_W-1:0] i,
                                                     input logic [31:0] w);
        put_word = b;
        put_word[i * WORD_BITS +: WORD_BITS] = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Slow outside clocks are synchronised by edge monitors; only the two master clocks are watched.
    cub_edge_mon u_rx_mon (.hclk(hclk), .hresetn(hresetn), .sig_in(rx_link_clk),
                           .rise(rx_rise), .alive());
    cub_edge_mon u_tx_mon (.hclk(hclk), .hresetn(hresetn), .sig_in(tx_link_clk),
                           .rise(tx_rise), .alive());
    cub_edge_mon u_rm_mon (.hclk(hclk), .hresetn(hresetn), .sig_in(recovered_master_clock),
                           .rise(), .alive(rm_alive));
    cub_edge_mon u_om_mon (.hclk(hclk), .hresetn(hresetn), .sig_in(output_master_clock),
                           .rise(), .alive(om_alive));

    ////////////////////////////////////////////////////////////////////////////////
    // Decodes shared by the next-state logic and the checks.
    always_comb begin
        run_ok = q.ctrl.run & rm_alive & om_alive;
        in_buf = (q.addr >= ADDR_BUF_BASE) && (q.addr <= ADDR_BUF_LAST);
        widx = WIDX_W'((q.addr - ADDR_BUF_BASE) >> 2);
        rx_eff = (q.rx_s2.blk_start && !q.rx_s2.sub_b) ? POS_FIRST : q.rx_pos;
        cap_done = rx_rise && run_ok && (rx_eff == POS_LAST);
        tx_done = tx_rise && run_ok && (q.tx_pos == POS_LAST);
        pend_now = |(q.st0 & q.en0) | |(q.st1 & q.en1);
        tx_u_bit = q.tx_u[q.tx_pos];
        tx_cs_bit = q.tx_cs[cs_index(q.tx_pos)];
        fixed_part = q.tx_cs & FIX_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: bus slave, receive capture, transmit, interrupts.
    always_comb begin
        d = q;
        ev0 = '0;
        ev1 = '0;
        clr0 = '0;
        clr1 = '0;
        d.rx_s1 = rx_link;
        d.rx_s2 = q.rx_s1;
        d.resp = 1'b0;
        // Bus slave: one wait state, then the data phase completes.
        if (q.ph == PH_IDLE) begin
            d.hrdy = 1'b1;
            if (hsel && htrans[1] && hready) begin
                d.ph = PH_ACCESS;
                d.hrdy = 1'b0;
                d.wr = hwrite && (hsize == HSIZE_WORD);
                d.addr = haddr[ADDR_W-1:0];
            end
        end else begin
            d.ph = PH_IDLE;
            d.hrdy = 1'b1;
            d.rdata = '0;
            if (q.wr) begin
                // register writes need no master clock
                unique case (q.addr)
                    ADDR_CTRL: d.ctrl = cub_ctrl_t'(hwdata[CTRL_W-1:0]);
                    ADDR_ICLR0: clr0 = hwdata[EV_W-1:0];
                    ADDR_IEN0: d.en0 = hwdata[EV_W-1:0];
                    ADDR_ICLR1: clr1 = hwdata[EV_W-1:0];
                    ADDR_IEN1: d.en1 = hwdata[EV_W-1:0];
                    default: begin
                        if (in_buf && run_ok) begin
                            if (!q.ctrl.buffer_kind_select) begin
                                d.acc_cs = put_word(q.acc_cs, widx, hwdata);
                            // user bits locked in auto mode
                            end else if (!q.ctrl.auto_user) begin
                                d.acc_u = put_word(q.acc_u, widx, hwdata);
                            end
                        end
                    end
                endcase
            end else begin
                unique case (q.addr)
                    ADDR_CTRL: d.rdata = 32'(q.ctrl);
                    ADDR_STATUS: d.rdata = {15'h0000, q.rx_pos, 5'h00, om_alive, rm_alive,
                                            run_ok};
                    ADDR_IST0: d.rdata = 32'(q.st0);
                    ADDR_IEN0: d.rdata = 32'(q.en0);
                    ADDR_IST1: d.rdata = 32'(q.st1);
                    ADDR_IEN1: d.rdata = 32'(q.en1);
                    default: begin
                        if (in_buf && run_ok) begin
                            d.rdata = q.ctrl.buffer_kind_select ? get_word(q.acc_u, widx)
                                                                : get_word(q.acc_cs, widx);
                        end
                    end
                endcase
            end
        end
        if (rx_rise && run_ok) begin
            // channel A then channel B layout
            d.cap_cs[cs_index(rx_eff)] = q.rx_s2.cs;
            d.cap_u[rx_eff] = q.rx_s2.user;
            d.rx_pos = rx_eff + 1'b1;
            // full block moves to access stage
            if (cap_done) begin
                d.acc_cs = d.cap_cs;
                d.acc_u = d.cap_u;
                d.rx_pos = POS_FIRST;
                ev0[EV0_CAPTURE] = 1'b1;
            end
        end
        if (tx_rise && run_ok) begin
            d.txo.cs = tx_cs_bit;
            d.txo.user = tx_u_bit;
            d.txo.sub_b = q.tx_pos[0];
            d.txo.blk_start = (q.tx_pos == POS_FIRST);
            d.tx_pos = q.tx_pos + 1'b1;
            // reload transmit stage after last bit
            if (tx_done) begin
                d.tx_u = d.acc_u;
                d.tx_cs = d.acc_cs;
                // keep the fixed first five bytes
                if (q.ctrl.fixed_cs && q.fixed_done) begin
                    d.tx_cs = (d.acc_cs & ~FIX_MASK) | fixed_part;
                end
                d.fixed_done = q.ctrl.fixed_cs;
                d.tx_pos = POS_FIRST;
                ev0[EV0_TXLOAD] = 1'b1;
            end
        end
        if (!q.ctrl.fixed_cs) begin
            d.fixed_done = 1'b0;
        end
        // Loss of a master clock raises an event once.
        d.rm_prev = rm_alive;
        d.om_prev = om_alive;
        ev1[EV1_RECOVERED_MASTER_CLOCK_LOST] = q.rm_prev & ~rm_alive;
        ev1[EV1_OUTPUT_MASTER_CLOCK_LOST] = q.om_prev & ~om_alive;
        // sticky status, set wins over clear
        d.st0 = (q.st0 & ~clr0) | ev0;
        d.st1 = (q.st1 & ~clr1) | ev1;
        d.pend = |(d.st0 & d.en0) | |(d.st1 & d.en1);
        // output format chosen by control field
        unique case (d.ctrl.ifmt)
            IFMT_HIGH: d.irq = d.pend;
            IFMT_LOW: d.irq = ~d.pend;
            IFMT_PULSE: d.irq = d.pend & ~q.pend;
            default: d.irq = d.pend;
        endcase
    end

    // state register holds all six buffers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.hrdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign hreadyout = q.hrdy;
    assign hrdata = q.rdata;
    assign hresp = q.resp;
    assign tx_link = q.txo;
    assign serial_mode = q.ctrl.serial_mode;
    assign irq = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_bus_wait_state: assert property (
        (q.ph == PH_IDLE && hsel && htrans[1] && hready) |=> s_wait_then_ready)
        else $error("bus transfer did not complete after one wait state");

    chk_capture_copy: assert property (
        cap_done |=> (q.acc_cs == q.cap_cs) && (q.acc_u == q.cap_u) && q.st0[EV0_CAPTURE])
        else $error("captured block not copied to access stage");

    chk_tx_reload: assert property (
        (tx_done && !(q.ctrl.fixed_cs && q.fixed_done))
        |=> (q.tx_cs == q.acc_cs) && (q.tx_u == q.acc_u) && (q.tx_pos == POS_FIRST))
        else $error("transmit stage not reloaded after last bit");

    chk_gate_stop: assert property (
        !run_ok |=> $stable(q.cap_cs) && $stable(q.acc_u) && $stable(q.tx_pos))
        else $error("buffers moved while stopped");

    chk_kind_route: assert property (
        (q.ph == PH_ACCESS && q.wr && in_buf && q.ctrl.buffer_kind_select && !cap_done)
        |=> $stable(q.acc_cs))
        else $error("user buffer write reached status buffer");

    chk_tx_bits: assert property (
        (tx_rise && run_ok) |=> (tx_link.user == $past(tx_u_bit))
                                && (tx_link.cs == $past(tx_cs_bit)))
        else $error("sent bit differs from transmit buffer");

    chk_fixed_hold: assert property (
        (tx_done && q.ctrl.fixed_cs && q.fixed_done) |=> fixed_part == $past(fixed_part))
        else $error("fixed status bytes changed");

    chk_user_locked: assert property (
        (q.ph == PH_ACCESS && q.wr && in_buf && q.ctrl.auto_user && !cap_done)
        |=> $stable(q.acc_u))
        else $error("user buffer written in auto user mode");

    chk_irq_level: assert property (
        (q.ctrl.ifmt == IFMT_HIGH && pend_now) [*2] |-> irq)
        else $error("interrupt low while an enabled event is pending");

    chk_irq_pulse: assert property (
        (q.ctrl.ifmt == IFMT_PULSE && irq) ##1 (q.ctrl.ifmt == IFMT_PULSE) |-> !irq)
        else $error("interrupt pulse lasted more than one cycle");

    chk_set_wins: assert property (
        (ev0[EV0_CAPTURE] && clr0[EV0_CAPTURE]) |=> q.st0[EV0_CAPTURE])
        else $error("event lost to a simultaneous clear");

endmodule // cub_buffer

// >>> bench/cub_link_partner.sv
// Behavioural link partner: feeds receive subframes and records transmitted subframes.
`timescale 1ns/1ns
module cub_link_partner (
    input wire logic rx_en,
    output logic rx_link_clk,
    output cub_pkg::cub_link_t rx_link,
    input wire logic tx_en,
    output logic tx_link_clk,
    input wire cub_pkg::cub_link_t tx_link,
    output int rx_count,
    output int tx_count,
    output int tx_bad,
    output logic [383:0] tx_cs_seen,
    output logic [383:0] tx_u_seen
);
    import cub_pkg::*;

    int p;
    int tp;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive side: data changes while the clock is low, clock stands still while rx_en is low.
    initial begin
        rx_link_clk = 1'b0;
        rx_link = '0;
        rx_count = 0;
        forever begin
            if (rx_en) begin
                p = rx_count % 384;
                rx_link = '{blk_start: (p == 0), sub_b: p[0], user: (p % 5 == 1), cs: (p % 3 == 0)};
                #80 rx_link_clk = 1'b1;
                #80 rx_link_clk = 1'b0;
                rx_count++;
            end else begin
                // Idle data keeps toggling so a stale value is never mistaken for data.
                rx_link = ~rx_link;
                #80;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit side: each rising edge asks for a subframe, sampled half a period later.
    initial begin
        tx_link_clk = 1'b0;
        tx_count = 0;
        tx_bad = 0;
        tp = 0;
        tx_cs_seen = '0;
        tx_u_seen = '0;
        forever begin
            if (tx_en) begin
                #80 tx_link_clk = 1'b1;
                #80 tx_link_clk = 1'b0;
                tp = tx_link.blk_start ? 0 : (tp + 1) % 384;
                tx_cs_seen[tp] = tx_link.cs;
                tx_u_seen[tp] = tx_link.user;
                if (tx_link.sub_b !== tp[0]) begin
                    tx_bad++;
                end
                tx_count++;
            end else begin
                #80;
            end
        end
    end

endmodule // cub_link_partner

// >>> bench/cub_buffer_tb.sv
// Self-checking testbench for the channel-status and user-bit buffer.
`timescale 1ns/1ns
module cub_buffer_tb;
    import cub_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = '0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic rx_link_clk;
    logic tx_link_clk;
    cub_link_t rx_link;
    cub_link_t tx_link;
    logic rmclk = 1'b0;
    logic omclk = 1'b0;
    logic rm_on = 1'b0;
    logic om_on = 1'b0;
    logic rx_en = 1'b0;
    logic tx_en = 1'b0;
    logic serial_mode;
    logic irq;
    int rx_count;
    int tx_count;
    int tx_bad;
    logic [383:0] tx_cs_seen;
    logic [383:0] tx_u_seen;
    logic [383:0] exp_cs;
    logic [383:0] exp_u;
    logic [383:0] got_cs;
    int mismatches = 0;
    int n_checks = 0;
    int p;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus clock, and master clocks that the bench can stop.
    always #5 hclk = ~hclk;
    always begin
        #50;
        if (rm_on) rmclk = ~rmclk;
        if (om_on) omclk = ~omclk;
    end

    cub_buffer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_link_clk(rx_link_clk),
        .rx_link(rx_link), .tx_link_clk(tx_link_clk), .tx_link(tx_link),
        .recovered_master_clock(rmclk), .output_master_clock(omclk),
        .serial_mode(serial_mode), .irq(irq));

    cub_link_partner partner_u (.rx_en(rx_en), .rx_link_clk(rx_link_clk), .rx_link(rx_link),
        .tx_en(tx_en), .tx_link_clk(tx_link_clk), .tx_link(tx_link), .rx_count(rx_count),
        .tx_count(tx_count), .tx_bad(tx_bad), .tx_cs_seen(tx_cs_seen), .tx_u_seen(tx_u_seen));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, bus access and closing tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    // access paced by ready
    // Ready is sampled in the low half so the value at the next rising edge is certain.
    task automatic wait_ready(output logic [31:0] q);
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        logic [31:0] tmp;
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready(tmp);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready(q);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    function automatic logic [11:0] bw(input int i);
        return ADDR_BUF_BASE + 12'(4 * i);
    endfunction

    // Runs the transmit link up to a total of n subframes, then unscrambles the status bits.
    // The partner is stopped one subframe early so that it sends no edge beyond n.
    task automatic run_tx(input int n);
        tx_en = 1'b1;
        while (tx_count < n - 1) @(posedge hclk);
        tx_en = 1'b0;
        while (tx_count < n) @(posedge hclk);
        repeat (4) @(posedge hclk);
        for (int q = 0; q < 384; q++) got_cs[q[0] ? 192 + (q >> 1) : q >> 1] = tx_cs_seen[q];
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short well beyond the expected run time.
    initial begin
        #500000;
        mismatches++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main test sequence.
    initial begin
        for (int b = 0; b < 384; b++) begin
            p = (b < 192) ? 2 * b : 2 * (b - 192) + 1;
            exp_cs[b] = (p % 3 == 0);
            exp_u[b] = (b % 5 == 1);
        end
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Registers with both master clocks stopped.
        rdc(ADDR_CTRL, 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        rdc(12'h040, 32'h0);
        wr(12'h040, 32'hffffffff);
        rdc(12'h040, 32'h0);
        wr(ADDR_CTRL, 32'h11);
        rdc(ADDR_CTRL, 32'h11);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, serial_mode}, 32'h1);
        wr(bw(0), 32'h89abcdef);
        rdc(bw(0), 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test stopped_clocks done");
        // Master clocks running: software access to both access buffers.
        rm_on = 1'b1;
        om_on = 1'b1;
        repeat (50) @(posedge hclk);
        rdc(ADDR_STATUS, 32'h7);
        wr(ADDR_CTRL, 32'h01);
        wr(bw(0), 32'h1234abcd);
        wr(ADDR_CTRL, 32'h03);
        wr(bw(0), 32'h5a5a0f0f);
        rdc(bw(0), 32'h5a5a0f0f);
        wr(ADDR_CTRL, 32'h0b);
        wr(bw(1), 32'hffffffff);
        rdc(bw(1), 32'h0);
        wr(ADDR_CTRL, 32'h01);
        rdc(bw(0), 32'h1234abcd);
        $display("test access_select done");
        // One received block lands in the access buffers and raises the interrupt.
        wr(ADDR_IEN0, 32'h1);
        // The partner is stopped one subframe early so that exactly one block is sent.
        rx_en = 1'b1;
        while (rx_count < 383) @(posedge hclk);
        rx_en = 1'b0;
        while (rx_count < 384) @(posedge hclk);
        repeat (20) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        rdc(ADDR_IST0, 32'h1);
        rdc(ADDR_STATUS, 32'h7);
        for (int i = 0; i < 12; i++) rdc(bw(i), exp_cs[32 * i +: 32]);
        wr(ADDR_CTRL, 32'h03);
        for (int i = 0; i < 12; i++) rdc(bw(i), exp_u[32 * i +: 32]);
        wr(ADDR_ICLR0, 32'h1);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        rdc(ADDR_IST0, 32'h0);
        wr(ADDR_CTRL, 32'h21);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        $display("test receive_block done");
        // Transmit: first block empty, second carries access contents incl. a software edit.
        // Fixed mode is on: its first reload still loads every bit.
        wr(ADDR_CTRL, 32'h05);
        wr(bw(3), 32'hc0ffee11);
        exp_cs[127:96] = 32'hc0ffee11;
        run_tx(768);
        for (int i = 0; i < 12; i++) check(got_cs[32 * i +: 32], exp_cs[32 * i +: 32]);
        for (int i = 0; i < 12; i++) check(tx_u_seen[32 * i +: 32], exp_u[32 * i +: 32]);
        check(32'(tx_bad), 32'h0);
        rdc(ADDR_IST0, 32'h2);
        check({31'h0, irq}, 32'h0);
        // Later reloads keep the first five status bytes but take the rest from access.
        wr(bw(0), 32'h0f0f0f0f);
        wr(bw(2), 32'h0f0f0f0f);
        exp_cs[95:64] = 32'h0f0f0f0f;
        run_tx(1536);
        for (int i = 0; i < 12; i++) check(got_cs[32 * i +: 32], exp_cs[32 * i +: 32]);
        $display("test transmit_block done");
        // Losing the recovered clock stops the buffers.
        // The loss is signalled in pulse format, so the line is low again afterwards.
        wr(ADDR_IEN1, 32'h1);
        wr(ADDR_CTRL, 32'h41);
        rm_on = 1'b0;
        repeat (250) @(posedge hclk);
        rdc(ADDR_STATUS, 32'h4);
        rdc(ADDR_IST1, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_CTRL, 32'h01);
        check({31'h0, irq}, 32'h1);
        rdc(bw(0), 32'h0);
        $display("test clock_loss done");
        conclude();
    end

endmodule // cub_buffer_tb
